// [common/ppfm_pkg.sv]
// Constants, register map and carrier types of the Port A pin function mux.
// Assumes one system clock and a plain address/strobe register port.

package ppfm_pkg;

  // ********************************
  // Register map
  // ********************************
  localparam logic [2:0] OFS_DATA   = 3'h0;
  localparam logic [2:0] OFS_DIR    = 3'h1;
  localparam logic [2:0] OFS_WAKE   = 3'h2;
  localparam logic [2:0] OFS_SEL_LO = 3'h3;
  localparam logic [2:0] OFS_SEL_UP = 3'h4;

  // ********************************
  // Field positions and codes
  // ********************************
  localparam int unsigned LINE0_LSB = 0;
  localparam int unsigned LINE1_LSB = 2;
  localparam int unsigned LINE2_LSB = 4;
  localparam int unsigned LINE3_LSB = 6;
  localparam int unsigned LINE4_LSB = 0;
  localparam int unsigned LINE5_LSB = 2;
  localparam int unsigned LINE6_LSB = 4;
  localparam logic [1:0]  SEL_ALT   = 2'h1;

  localparam logic [7:0] UP_MASK_SMALL = 8'h0F;
  localparam logic [7:0] UP_MASK_LARGE = 8'h3F;

  // ********************************
  // Reset values
  // ********************************
  localparam logic [6:0] DATA_RST = 7'h7F;
  localparam logic [6:0] DIR_RST  = 7'h7F;
  localparam logic [6:0] WAKE_RST = 7'h00;
  localparam logic [7:0] SEL_RST  = 8'h00;

  // ********************************
  // Carrier types
  // ********************************
  typedef struct packed {
    logic pt_out;
    logic pt_out_inv;
    logic ct_out;
    logic ct_out_inv;
  } ppfm_tmr_t;

  typedef struct packed {
    logic irq0;
    logic irq1;
    logic pt_clk;
    logic pt_cap;
  } ppfm_periph_t;

  typedef struct packed {
    logic [6:0]   data;
    logic [6:0]   dir;
    logic [6:0]   wake_en;
    logic [7:0]   sel_lo;
    logic [7:0]   sel_up;
    logic [6:0]   sync1;
    logic [6:0]   sync2;
    logic [6:0]   prev;
    logic [7:0]   rdata;
    logic [6:0]   pad_out;
    logic [6:0]   pad_oe_n;
    ppfm_periph_t periph;
    logic         wake;
  } ppfm_state_t;

  localparam ppfm_state_t STATE_RST = '{
    data: DATA_RST, dir: DIR_RST, wake_en: WAKE_RST,
    sel_lo: SEL_RST, sel_up: SEL_RST,
    sync1: 7'h7F, sync2: 7'h7F, prev: 7'h7F,
    rdata: 8'h00, pad_out: DATA_RST, pad_oe_n: DIR_RST,
    periph: 4'hF, wake: 1'b0};

endpackage : ppfm_pkg

// [hdl/ppfm_port_a.sv]
// Port A pin function mux: port latch, direction, wake-up and
// per-pin selection between GPIO and timer/interrupt signals.
// Assumes timer outputs and HALT come from logic on CLK; pins are async.
//
// Overview of operation
// RULE1: Line3 always GPIO, feeds interrupt input 0
// RULE2: Line2 code 01 drives periodic timer output
// RULE3: Line1 always GPIO, feeds periodic timer clock
// RULE4: Line0 code 01 inverted output, else capture
// RULE5: Line5 code 01 drives compact timer output
// RULE6: Line4 always GPIO, feeds interrupt input 1
// RULE7: Unimplemented upper select bits read zero
// RULE8: Line6 code 01 drives compact inverted output
// RULE9: Software sets direction input for shared inputs
// RULE10: Software selects pin, configures, then enables
// RULE11: Software disables peripheral before reselecting pin
// RULE12: Reset sets all data and direction high
// RULE13: New output drives high without data write
// RULE14: Bit set/clear reads, modifies, writes byte
// RULE15: Halted falling edge on enabled pin wakes
// RULE16: Select registers reset so pins are GPIO
//
// The implementer's own choices: the strobed register port and the register addresses.

`timescale 1ns/1ps

module ppfm_port_a #(
  parameter bit LARGE_PKG = 1'b1
) (
  input  wire logic                  CLK,
  input  wire logic                  SYS_RST,
  input  wire logic [2:0]            ADDR,
  input  wire logic [7:0]            WR_DATA,
  input  wire logic                  WR_STB,
  input  wire logic                  RD_STB,
  input  wire logic                  BIT_SET,
  input  wire logic                  BIT_CLR,
  input  wire logic [2:0]            BIT_IDX,
  output logic [7:0]                 RD_DATA,
  input  wire logic [6:0]            PA_IN,
  output logic [6:0]                 PA_OUT,
  output logic [6:0]                 PA_OE_N,
  input  wire ppfm_pkg::ppfm_tmr_t   TMR_OUT,
  output ppfm_pkg::ppfm_periph_t     PERIPH_IN,
  input  wire logic                  HALT,
  output logic                       WAKE
);

  // ********************************
  // State
  // ********************************
  ppfm_pkg::ppfm_state_t s_reg;
  ppfm_pkg::ppfm_state_t s_next;

  logic [7:0] up_mask;
  logic [6:0] port_view;
  logic [7:0] reg_view;
  logic [7:0] mod_view;
  logic [7:0] wr_val;
  logic       wr_any;
  logic [6:0] alt_en;
  logic [6:0] alt_val;
  logic [6:0] pad_out_d;
  logic [6:0] pad_oe_d;
  logic [6:0] gpio_in;
  logic [6:0] wake_hit;

  // Upper select width follows the package variant
  assign up_mask = LARGE_PKG ? ppfm_pkg::UP_MASK_LARGE : ppfm_pkg::UP_MASK_SMALL;

  // Inputs read the pin, outputs read back the latch, not the pad
  assign port_view = (s_reg.dir & s_reg.sync2) | (~s_reg.dir & s_reg.data);

  // ********************************
  // Register view and bit operations
  // ********************************

  // Readable value of the addressed register
  always_comb begin
    if (ADDR == ppfm_pkg::OFS_DATA) begin
      reg_view = {1'b0, port_view};
    end else if (ADDR == ppfm_pkg::OFS_DIR) begin
      reg_view = {1'b0, s_reg.dir};
    end else if (ADDR == ppfm_pkg::OFS_WAKE) begin
      reg_view = {1'b0, s_reg.wake_en};
    end else if (ADDR == ppfm_pkg::OFS_SEL_LO) begin
      reg_view = s_reg.sel_lo;
    end else if (ADDR == ppfm_pkg::OFS_SEL_UP) begin
      reg_view = s_reg.sel_up;
    end else begin
      reg_view = 8'h00;
    end
  end

  // Whole byte is read, one bit changed, then written back, so input
  // pins of the data register pick up their pin level [RULE14]
  always_comb begin
    mod_view = reg_view;
    mod_view[BIT_IDX] = BIT_SET;
  end

  // A plain write wins over a bit operation in the same cycle
  assign wr_val = WR_STB ? WR_DATA : mod_view;
  assign wr_any = WR_STB | BIT_SET | BIT_CLR;

  // ********************************
  // Pin function selection
  // ********************************

  // Code 01 hands the pad to a timer output [RULE2] [RULE4] [RULE5] [RULE8]
  assign alt_en = {
    LARGE_PKG && (s_reg.sel_up[ppfm_pkg::LINE6_LSB +: 2] == ppfm_pkg::SEL_ALT),
    s_reg.sel_up[ppfm_pkg::LINE5_LSB +: 2] == ppfm_pkg::SEL_ALT,
    1'b0,
    1'b0,
    s_reg.sel_lo[ppfm_pkg::LINE2_LSB +: 2] == ppfm_pkg::SEL_ALT,
    1'b0,
    s_reg.sel_lo[ppfm_pkg::LINE0_LSB +: 2] == ppfm_pkg::SEL_ALT
  };

  assign alt_val = {
    TMR_OUT.ct_out_inv,
    TMR_OUT.ct_out,
    1'b0,
    1'b0,
    TMR_OUT.pt_out,
    1'b0,
    TMR_OUT.pt_out_inv
  };

  // Per-pin pad mux; GPIO drives the latch, so a fresh output is high
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_pad
      assign pad_out_d[gi] = alt_en[gi] ? alt_val[gi] : s_reg.data[gi]; // [RULE13]
      assign pad_oe_d[gi]  = alt_en[gi] ? 1'b0 : s_reg.dir[gi];
    end
  endgenerate

  // ********************************
  // Wake-up
  // ********************************

  // Only GPIO inputs may wake; edge seen on settled samples only
  assign gpio_in  = s_reg.dir & ~alt_en;
  assign wake_hit = s_reg.wake_en & gpio_in & s_reg.prev & ~s_reg.sync2;

  // ********************************
  // Next state
  // ********************************

  // Register updates, synchronisers and registered outputs
  always_comb begin
    s_next = s_reg;
    s_next.sync1 = PA_IN;
    s_next.sync2 = s_reg.sync1;
    s_next.prev  = s_reg.sync2;
    s_next.rdata = RD_STB ? reg_view : 8'h00;
    if (wr_any) begin
      if (ADDR == ppfm_pkg::OFS_DATA) begin
        s_next.data = wr_val[6:0];
      end else if (ADDR == ppfm_pkg::OFS_DIR) begin
        s_next.dir = wr_val[6:0];
      end else if (ADDR == ppfm_pkg::OFS_WAKE) begin
        s_next.wake_en = wr_val[6:0];
      end else if (ADDR == ppfm_pkg::OFS_SEL_LO) begin
        s_next.sel_lo = wr_val;
      end else if (ADDR == ppfm_pkg::OFS_SEL_UP) begin
        s_next.sel_up = wr_val & up_mask; // [RULE7]
      end
    end
    s_next.pad_out  = pad_out_d;
    s_next.pad_oe_n = pad_oe_d;
    // Shared inputs follow the pin whatever the select code, except capture, which line0 code 01 holds low
    s_next.periph.irq0   = s_reg.sync2[3]; // [RULE1]
    s_next.periph.irq1   = s_reg.sync2[4]; // [RULE6]
    s_next.periph.pt_clk = s_reg.sync2[1]; // [RULE3]
    s_next.periph.pt_cap = s_reg.sync2[0] & ~alt_en[0]; // [RULE4]
    s_next.wake = HALT & (|wake_hit); // [RULE15]
  end

  // Synchronous reset: latches and directions high, selects GPIO
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      s_reg <= ppfm_pkg::STATE_RST; // [RULE12] [RULE16]
    end else begin
      s_reg <= s_next;
    end
  end

  assign RD_DATA   = s_reg.rdata;
  assign PA_OUT    = s_reg.pad_out;
  assign PA_OE_N   = s_reg.pad_oe_n;
  assign PERIPH_IN = s_reg.periph;
  assign WAKE      = s_reg.wake;

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  logic [6:0] clr_mask;
  assign clr_mask = 7'h01 << BIT_IDX;

  sequence s_quiet3;
    !$past(SYS_RST) && !$past(SYS_RST, 2) && !$past(SYS_RST, 3);
  endsequence

  property p_reset_gpio;
    disable iff (1'b0)
    SYS_RST |=> s_reg.data == 7'h7F && s_reg.dir == 7'h7F
      && s_reg.sel_lo == 8'h00 && s_reg.sel_up == 8'h00;
  endproperty
  a_reset_gpio: assert property (p_reset_gpio) // [RULE12]
    else $error("Reset did not leave pins as GPIO inputs");

  property p_line3_irq;
    s_quiet3 |-> PERIPH_IN.irq0 == $past(PA_IN[3], 3);
  endproperty
  a_line3_irq: assert property (p_line3_irq) // [RULE1]
    else $error("Interrupt input 0 does not follow line3");

  property p_line2_alt;
    s_reg.sel_lo[5:4] == 2'h1 |=> PA_OUT[2] == $past(TMR_OUT.pt_out) && !PA_OE_N[2];
  endproperty
  a_line2_alt: assert property (p_line2_alt) // [RULE2]
    else $error("Line2 not driven by periodic timer output");

  property p_line1_clk;
    s_quiet3 |-> PERIPH_IN.pt_clk == $past(PA_IN[1], 3);
  endproperty
  a_line1_clk: assert property (p_line1_clk) // [RULE3]
    else $error("Timer clock input does not follow line1");

  property p_line0_mux;
    s_reg.sel_lo[1:0] == 2'h1
      |=> PA_OUT[0] == $past(TMR_OUT.pt_out_inv) && !PA_OE_N[0] && !PERIPH_IN.pt_cap;
  endproperty
  a_line0_mux: assert property (p_line0_mux) // [RULE4]
    else $error("Line0 inverted output or capture gating wrong");

  property p_line5_alt;
    s_reg.sel_up[3:2] == 2'h1 |=> PA_OUT[5] == $past(TMR_OUT.ct_out) && !PA_OE_N[5];
  endproperty
  a_line5_alt: assert property (p_line5_alt) // [RULE5]
    else $error("Line5 not driven by compact timer output");

  property p_line4_irq;
    s_quiet3 |-> PERIPH_IN.irq1 == $past(PA_IN[4], 3);
  endproperty
  a_line4_irq: assert property (p_line4_irq) // [RULE6]
    else $error("Interrupt input 1 does not follow line4");

  property p_up_unused;
    RD_STB && ADDR == ppfm_pkg::OFS_SEL_UP |=> RD_DATA[7:6] == 2'h0 && (LARGE_PKG || RD_DATA[5:4] == 2'h0);
  endproperty
  a_up_unused: assert property (p_up_unused) // [RULE7]
    else $error("Unimplemented select bits read nonzero");

  property p_line6_alt;
    LARGE_PKG && s_reg.sel_up[5:4] == 2'h1 |=> PA_OUT[6] == $past(TMR_OUT.ct_out_inv) && !PA_OE_N[6];
  endproperty
  a_line6_alt: assert property (p_line6_alt) // [RULE8]
    else $error("Line6 not driven by compact inverted output");

  property p_gpio_pad;
    s_reg.sel_lo[5:4] != 2'h1 |=> PA_OUT[2] == $past(s_reg.data[2]) && PA_OE_N[2] == $past(s_reg.dir[2]);
  endproperty
  a_gpio_pad: assert property (p_gpio_pad) // [RULE13]
    else $error("GPIO pad does not follow latch and direction");

  property p_rmw_clr;
    BIT_CLR && !BIT_SET && !WR_STB && ADDR == ppfm_pkg::OFS_DATA && BIT_IDX != 3'h7
      |=> s_reg.data == ($past(port_view) & ~$past(clr_mask));
  endproperty
  a_rmw_clr: assert property (p_rmw_clr) // [RULE14]
    else $error("Bit clear did not write back the read port");

  property p_wake;
    $rose(WAKE) |-> $past(HALT) && ($past(s_reg.wake_en & ~s_reg.sync2 & s_reg.prev) != 7'h00);
  endproperty
  a_wake: assert property (p_wake) // [RULE15]
    else $error("Wake raised without halted falling edge");

  property p_sel_default;
    $past(SYS_RST) |-> alt_en == 7'h00;
  endproperty
  a_sel_default: assert property (p_sel_default) // [RULE16]
    else $error("A pin left reset in a shared function");

  // Reset also parks every pad as an input showing a high latch
  property p_reset_pads;
    disable iff (1'b0)
    SYS_RST |=> PA_OUT == ppfm_pkg::DATA_RST && PA_OE_N == ppfm_pkg::DIR_RST;
  endproperty
  a_reset_pads: assert property (p_reset_pads) // [RULE12]
    else $error("Reset did not park the pads as inputs");

  // Bit set on the direction register keeps every other bit
  property p_rmw_set;
    BIT_SET && !WR_STB && ADDR == ppfm_pkg::OFS_DIR && BIT_IDX != 3'h7
      |=> s_reg.dir == ($past(s_reg.dir) | $past(clr_mask));
  endproperty
  a_rmw_set: assert property (p_rmw_set) // [RULE14]
    else $error("Bit set did not write back the read register");

  // Unimplemented upper select bits never hold a written one
  property p_sel_up_mask;
    WR_STB && ADDR == ppfm_pkg::OFS_SEL_UP
      |=> s_reg.sel_up[7:6] == 2'h0 && (LARGE_PKG || s_reg.sel_up[5:4] == 2'h0);
  endproperty
  a_sel_up_mask: assert property (p_sel_up_mask) // [RULE7]
    else $error("Unimplemented select bits took a write");

  // Line6 stays GPIO on the small package and for the other codes
  property p_line6_gpio;
    !(LARGE_PKG && s_reg.sel_up[5:4] == 2'h1)
      |=> PA_OUT[6] == $past(s_reg.data[6]) && PA_OE_N[6] == $past(s_reg.dir[6]);
  endproperty
  a_line6_gpio: assert property (p_line6_gpio) // [RULE8]
    else $error("Line6 left GPIO without its select code");

  // Line5 is plain GPIO unless its code is 01
  property p_line5_gpio;
    s_reg.sel_up[3:2] != 2'h1
      |=> PA_OUT[5] == $past(s_reg.data[5]) && PA_OE_N[5] == $past(s_reg.dir[5]);
  endproperty
  a_line5_gpio: assert property (p_line5_gpio) // [RULE5]
    else $error("Line5 left GPIO without its select code");

  // Line0 without code 01 is GPIO and feeds the capture input
  property p_line0_gpio;
    s_reg.sel_lo[1:0] != 2'h1
      |=> PA_OUT[0] == $past(s_reg.data[0]) && PA_OE_N[0] == $past(s_reg.dir[0])
        && PERIPH_IN.pt_cap == $past(s_reg.sync2[0]);
  endproperty
  a_line0_gpio: assert property (p_line0_gpio) // [RULE4]
    else $error("Line0 GPIO or capture path wrong");

  // No wake request leaves the block while the device runs
  property p_wake_halt;
    !HALT |=> !WAKE;
  endproperty
  a_wake_halt: assert property (p_wake_halt) // [RULE15]
    else $error("Wake raised outside halt");

  // A wake request needs some enabled GPIO input line
  property p_wake_gpio;
    WAKE |-> $past(|(s_reg.wake_en & s_reg.dir & ~alt_en));
  endproperty
  a_wake_gpio: assert property (p_wake_gpio) // [RULE15]
    else $error("Wake raised with no enabled GPIO input");

  // Lines 1, 3 and 4 have no output function at any code
  property p_shared_pads;
    1'b1 |=> PA_OE_N[4:3] == $past(s_reg.dir[4:3]) && PA_OE_N[1] == $past(s_reg.dir[1])
      && PA_OUT[4:3] == $past(s_reg.data[4:3]) && PA_OUT[1] == $past(s_reg.data[1]);
  endproperty
  a_shared_pads: assert property (p_shared_pads) // [RULE1] [RULE3] [RULE6]
    else $error("Input-only shared line left GPIO");

endmodule : ppfm_port_a

// [bench/ppfm_far_end.sv]
// Far-side model: timer outputs and the Port A pad wires.
// Assumes the bench sets the outside pin levels on ext_lvl.
`timescale 1ns/1ps
module ppfm_far_end (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic [6:0]    pa_out,
  input  wire logic [6:0]    pa_oe_n,
  input  wire logic [6:0]    ext_lvl,
  output logic [6:0]         pa_in,
  output ppfm_pkg::ppfm_tmr_t tmr_out
);
  logic [3:0] cnt_reg;
  // Periodic outputs step every cycle, compact ones every second cycle, so a stale mux path shows up
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
  assign tmr_out = {cnt_reg[0], ~cnt_reg[0], cnt_reg[1], ~cnt_reg[1]};
  // Driven pads show the design's level, released pads the outside one
  assign pa_in = (pa_oe_n & ext_lvl) | (~pa_oe_n & pa_out);
endmodule : ppfm_far_end

// [bench/port_a_pin_function_mux_tb.sv]
// Self-checking bench of the Port A pin function mux.
// Assumes the far-side model and the register port of the design.
`timescale 1ns/1ps
module port_a_pin_function_mux_tb;
  logic [6:0] pa_in, pa_out, pa_oe_n, ext;
  logic [7:0] wdata, rdata, rdata_s;
  logic [6:0] pa_oe_n_s;
  logic [2:0] addr, bidx;
  logic clk, sys_rst, wr_stb, rd_stb, bset, bclr, halt, wake;
  ppfm_pkg::ppfm_tmr_t tmr;
  ppfm_pkg::ppfm_periph_t per;
  int fail_count, cmp_count;
  ppfm_port_a #(.LARGE_PKG(1'b1)) ppfm_port_a_i (.CLK(clk), .SYS_RST(sys_rst),
    .ADDR(addr), .WR_DATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb),
    .BIT_SET(bset), .BIT_CLR(bclr), .BIT_IDX(bidx), .RD_DATA(rdata),
    .PA_IN(pa_in), .PA_OUT(pa_out), .PA_OE_N(pa_oe_n), .TMR_OUT(tmr),
    .PERIPH_IN(per), .HALT(halt), .WAKE(wake));
  // Small package twin on the same bus and pins; only upper select and line6 differ
  ppfm_port_a #(.LARGE_PKG(1'b0)) ppfm_port_a_s_i (.CLK(clk), .SYS_RST(sys_rst),
    .ADDR(addr), .WR_DATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb),
    .BIT_SET(bset), .BIT_CLR(bclr), .BIT_IDX(bidx), .RD_DATA(rdata_s),
    .PA_IN(pa_in), .PA_OUT(), .PA_OE_N(pa_oe_n_s), .TMR_OUT(tmr),
    .PERIPH_IN(), .HALT(halt), .WAKE());
  ppfm_far_end ppfm_far_end_i (.clk(clk), .rst(sys_rst), .pa_out(pa_out),
    .pa_oe_n(pa_oe_n), .ext_lvl(ext), .pa_in(pa_in), .tmr_out(tmr));
  // ********************************
  // Shared tasks
  // ********************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  // Read data is taken at the edge after the one that samples the strobe
  task automatic rc(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(posedge clk);
    chk(rdata, exp);
    chk(rdata_s, a == ppfm_pkg::OFS_SEL_UP ? exp & ppfm_pkg::UP_MASK_SMALL : exp);
  endtask : rc
  task automatic bop(input logic s, input logic [2:0] a, input logic [2:0] i);
    @(posedge clk);
    addr <= a;
    bidx <= i;
    bset <= s;
    bclr <= !s;
    @(posedge clk);
    bset <= 1'b0;
    bclr <= 1'b0;
  endtask : bop
  task automatic drv(input logic [6:0] lvl, input logic h);
    @(posedge clk);
    ext <= lvl;
    halt <= h;
  endtask : drv
  // ********************************
  // Scenarios
  // ********************************
  task automatic t_reset();
    rc(ppfm_pkg::OFS_DATA, 8'h7F);
    rc(ppfm_pkg::OFS_DIR, 8'h7F);
    rc(ppfm_pkg::OFS_SEL_LO, 8'h00);
    rc(ppfm_pkg::OFS_SEL_UP, 8'h00);
    chk({1'b0, pa_oe_n}, 8'h7F);
    chk({4'h0, per}, 8'h0F);
    $display("test reset done");
  endtask : t_reset
  task automatic t_out_high();
    wr(ppfm_pkg::OFS_DIR, 8'h00);
    wt(2);
    chk({1'b0, pa_out}, 8'h7F);
    chk({1'b0, pa_oe_n}, 8'h00);
    wr(ppfm_pkg::OFS_DIR, 8'h7F);
    $display("test output high done");
  endtask : t_out_high
  // Same code on every field; upper bits 7:6 written but must stay zero
  task automatic t_sel();
    logic [7:0] s;
    logic alt;
    ppfm_pkg::ppfm_tmr_t p;
    for (int c = 0; c < 4; c++) begin
      s = 8'(c) * 8'h55;
      alt = (c == 1);
      wr(ppfm_pkg::OFS_SEL_LO, s);
      wr(ppfm_pkg::OFS_SEL_UP, s | 8'hC0);
      rc(ppfm_pkg::OFS_SEL_UP, s & 8'h3F);
      @(negedge clk);
      p = tmr;
      @(negedge clk);
      chk({1'b0, pa_oe_n}, alt ? 8'h1A : 8'h7F);
      chk({1'b0, pa_oe_n_s}, alt ? 8'h5A : 8'h7F);
      chk({1'b0, pa_out}, alt ? {1'b0, p.ct_out_inv, p.ct_out, 2'h3, p.pt_out, 1'b1, p.pt_out_inv}
        : 8'h7F);
      drv(7'h00, 1'b0);
      wt(4);
      chk({4'h0, per}, 8'h00);
      drv(7'h7F, 1'b0);
      wt(4);
      chk({4'h0, per}, {5'h07, !alt});
      wr(ppfm_pkg::OFS_SEL_LO, 8'h00);
      wr(ppfm_pkg::OFS_SEL_UP, 8'h00);
    end
    $display("test select done");
  endtask : t_sel
  // Clearing a bit must write back pin levels, not the stale latch
  task automatic t_rmw();
    drv(7'h55, 1'b0);
    wt(3);
    bop(1'b0, ppfm_pkg::OFS_DATA, 3'h2);
    wr(ppfm_pkg::OFS_DIR, 8'h00);
    wt(2);
    chk({1'b0, pa_out}, 8'h51);
    rc(ppfm_pkg::OFS_DATA, 8'h51);
    bop(1'b1, ppfm_pkg::OFS_DIR, 3'h3);
    rc(ppfm_pkg::OFS_DIR, 8'h08);
    wr(ppfm_pkg::OFS_DIR, 8'h7F);
    drv(7'h7F, 1'b0);
    wr(3'h5, 8'hFF);
    rc(3'h5, 8'h00);
    $display("test read-modify-write done");
  endtask : t_rmw
  task automatic t_wake();
    logic [7:0] n;
    wr(ppfm_pkg::OFS_WAKE, 8'h08);
    for (int h = 1; h >= 0; h--) begin
      n = 8'h00;
      wt(3);
      drv(7'h73, h[0]);
      repeat (6) begin
        @(posedge clk);
        n = n + {7'h00, wake};
      end
      chk(n, h[0] ? 8'h01 : 8'h00);
      drv(7'h7F, 1'b0);
    end
    // A falling output pin under halt must not wake
    wr(ppfm_pkg::OFS_DATA, 8'h7F);
    wr(ppfm_pkg::OFS_DIR, 8'h77);
    drv(7'h7F, 1'b1);
    wr(ppfm_pkg::OFS_DATA, 8'h77);
    n = 8'h00;
    repeat (6) begin
      @(posedge clk);
      n = n + {7'h00, wake};
    end
    chk(n, 8'h00);
    drv(7'h7F, 1'b0);
    wr(ppfm_pkg::OFS_DIR, 8'h7F);
    $display("test wake done");
  endtask : t_wake
  // ********************************
  // Sequence and verdict
  // ********************************
  task automatic tally_and_finish();
    $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  always #10 clk = ~clk;
  initial begin
    {clk, wr_stb, rd_stb, bset, bclr, halt, addr, bidx, wdata} = '0;
    sys_rst = 1'b1;
    ext = 7'h7F;
    fail_count = 0;
    cmp_count = 0;
    wt(6);
    sys_rst <= 1'b0;
    t_reset();
    t_out_high();
    t_sel();
    t_rmw();
    t_wake();
    tally_and_finish();
  end
  // Tests need well under 1000 cycles; cut off at 10000
  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end
endmodule : port_a_pin_function_mux_tb
